// ==== common/qsbp_pkg.sv ====
// package: constants and types of the burst sram port
// assumes: compiled before every other design file
package qsbp_pkg;
	localparam int QSBP_AW = 22;
	localparam int QSBP_DW = 36;
	localparam int QSBP_LANES = 4;
	localparam int QSBP_LANE_W = 9;
	localparam int QSBP_LOG_DEPTH = 16;
	localparam int QSBP_WB_AW = 4;
	localparam int QSBP_WB_DW = 32;
	localparam logic [QSBP_LANES-1:0] QSBP_NARROW_MASK = 4'h3;
	localparam logic [QSBP_AW-1:0] QSBP_WORD_STEP = 22'h00_0001;
	localparam logic [QSBP_AW-1:0] QSBP_PAIR_STEP = 22'h00_0002;
	localparam logic [QSBP_WB_AW-1:0] QSBP_REG_CTRL = 4'h0;
	localparam logic [QSBP_WB_AW-1:0] QSBP_REG_STATUS = 4'h4;
	localparam logic [QSBP_WB_AW-1:0] QSBP_REG_LOG = 4'h8;
	localparam int QSBP_CTRL_WIDE = 0;
	localparam logic QSBP_CTRL_WIDE_RST = 1'h1;
	localparam int QSBP_ST_RD_BUSY = 0;
	localparam int QSBP_ST_WR_BUSY = 1;
	localparam int QSBP_ST_OVF = 2;
	localparam int QSBP_ST_LOG_VALID = 3;
	localparam int QSBP_LOG_VALID = 31;
	typedef enum logic [1:0] {
		QSBP_LOP_NONE,
		QSBP_LOP_READ,
		QSBP_LOP_WRITE
	} qsbp_lop_t;
endpackage

// ==== common/qsbp_mem_if.sv ====
// interface: array ports between port logic and burst array
// assumes: one clock, shared by both ends
`timescale 1ns/10ps
`default_nettype none
interface qsbp_mem_if;
	import qsbp_pkg::*;
	logic [1:0] we;
	logic [1:0][QSBP_LANES-1:0] lane_en;
	logic [1:0][QSBP_AW-1:0] waddr;
	logic [1:0][QSBP_DW-1:0] wdata;
	logic re;
	logic [1:0][QSBP_AW-1:0] raddr;
	logic [1:0][QSBP_DW-1:0] rdata;
	modport ctrl (output we, lane_en, waddr, wdata, re, raddr,
		input rdata);
	modport mem (input we, lane_en, waddr, wdata, re, raddr,
		output rdata);
endinterface
`default_nettype wire

// ==== design/qsbp_mem.sv ====
// module: burst array, two lane-masked writes, two registered reads
// assumes: write addresses of one cycle differ
`timescale 1ns/10ps
`default_nettype none
module qsbp_mem
(
	input wire logic clk_i,
	input wire logic ce_i,
	qsbp_mem_if.mem port_if
);
	import qsbp_pkg::*;

	logic [QSBP_DW-1:0] store [2**QSBP_AW];
	logic [1:0][QSBP_DW-1:0] next_rdata;

	genvar p, l;
	generate
		for (p = 0; p < 2; p++)
		begin : g_port
			for (l = 0; l < QSBP_LANES; l++)
			begin : g_lane
				localparam int LO = l * QSBP_LANE_W;
				wire logic hit0 = port_if.we[0] && port_if.lane_en[0][l]
					&& port_if.waddr[0] == port_if.raddr[p];
				wire logic hit1 = port_if.we[1] && port_if.lane_en[1][l]
					&& port_if.waddr[1] == port_if.raddr[p];
				// newest write data wins over the array
				assign next_rdata[p][LO +: QSBP_LANE_W] = hit1 ?
					port_if.wdata[1][LO +: QSBP_LANE_W] : hit0 ?
					port_if.wdata[0][LO +: QSBP_LANE_W] :
					store[port_if.raddr[p]][LO +: QSBP_LANE_W];
			end
		end
	endgenerate

	always_ff @(posedge clk_i)
	begin
		if (ce_i)
		begin
			for (int w = 0; w < 2; w++)
				for (int k = 0; k < QSBP_LANES; k++)
					if (port_if.we[w] && port_if.lane_en[w][k])
						store[port_if.waddr[w]][k*QSBP_LANE_W +: QSBP_LANE_W]
							<= port_if.wdata[w][k*QSBP_LANE_W +: QSBP_LANE_W];
			if (port_if.re)
				port_if.rdata <= next_rdata;
		end
	end
endmodule // qsbp_mem
`default_nettype wire

// ==== design/qsbp_fifo.sv ====
// module: show-ahead fifo with valid and ready on both sides
// assumes: depth is a power of two
`timescale 1ns/10ps
`default_nettype none
module qsbp_fifo
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] slot [DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [PW:0] count;

	wire logic push = in_valid_i && in_ready_o;
	wire logic pop = out_valid_o && out_ready_i;
	assign in_ready_o = count != (PW+1)'(DEPTH);
	assign out_valid_o = count != '0;
	assign out_data_o = slot[rd_ptr];

	always_ff @(posedge clk_i)
	begin
		if (ce_i && push)
			slot[wr_ptr] <= in_data_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end
		else if (ce_i)
		begin
			wr_ptr <= wr_ptr + PW'(push);
			rd_ptr <= rd_ptr + PW'(pop);
			count <= count + (PW+1)'(push) - (PW+1)'(pop);
		end
	end
endmodule // qsbp_fifo
`default_nettype wire

// ==== design/qsbp_top.sv ====
// module: port logic of a four-word burst sram, separate data ports
// assumes: controller pins run on clk_i; wishbone master on clk_i
//
// Behaviour
// - write starts when write select low, read select high; address latched
// - four write words taken on the two edges after the start
// - read returns first word 2.5 cycles later, last at cycle t+4
// - burst words map to A, A+1, A+2, A+3 in order
// - select that started last cycle is don't-care now
// - back-to-back reads or writes: the second one is ignored
// - after reset deselected, read outputs high impedance
// - narrow mode: lane 0 bits 8..0, lane 1 bits 17..9
// - narrow mode: both lane selects high writes nothing
// - wide mode: lanes 0..3 guard bits 8..0 up to 35..27
// - wide mode: all four lane selects high writes nothing
// - lane selects sampled separately with every data word
// - both selects from idle: read first, then alternate
// - read right after write to same place gets new data
`timescale 1ns/10ps
`default_nettype none
module qsbp_top
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic read_port_select_n_i,
	input wire logic write_port_select_n_i,
	input wire logic [qsbp_pkg::QSBP_AW-1:0] addr_i,
	input wire logic [qsbp_pkg::QSBP_DW-1:0] d_k_i,
	input wire logic [qsbp_pkg::QSBP_DW-1:0] d_kn_i,
	input wire logic [qsbp_pkg::QSBP_LANES-1:0] byte_lane_write_select_k_i,
	input wire logic [qsbp_pkg::QSBP_LANES-1:0] byte_lane_write_select_kn_i,
	output logic [qsbp_pkg::QSBP_DW-1:0] q_k_o,
	output logic [qsbp_pkg::QSBP_DW-1:0] q_kn_o,
	output logic q_k_oe_o,
	output logic q_kn_oe_o,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [qsbp_pkg::QSBP_WB_AW-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [qsbp_pkg::QSBP_WB_DW-1:0] wb_dat_i,
	output logic [qsbp_pkg::QSBP_WB_DW-1:0] wb_dat_o,
	output logic wb_ack_o
);
	import qsbp_pkg::*;

	qsbp_lop_t last_op;
	qsbp_lop_t next_last_op;
	logic wide;
	logic ovf;
	logic [QSBP_AW-1:0] wa;
	logic [QSBP_AW-1:0] ra;
	logic wr_p1;
	logic wr_p2;
	logic rd_p1;
	logic rd_p2;
	logic rd_p3;
	logic rd_p4;
	logic [QSBP_DW-1:0] hold;
	logic [QSBP_DW-1:0] q_mask;
	logic log_ready;
	logic log_valid;
	logic [QSBP_AW-1:0] log_addr;
	logic [QSBP_WB_DW-1:0] status_word;
	logic [QSBP_WB_DW-1:0] ctrl_word;
	logic [QSBP_WB_DW-1:0] log_word;
	logic pop_log;

	qsbp_mem_if mem_if ();

	// request arbitration
	wire logic rd_req = !read_port_select_n_i;
	wire logic wr_req = !write_port_select_n_i;
	wire logic start_rd = rd_req
		&& last_op != QSBP_LOP_READ;
	wire logic start_wr = wr_req && !start_rd
		&& last_op != QSBP_LOP_WRITE;
	assign next_last_op = start_rd ? QSBP_LOP_READ :
		start_wr ? QSBP_LOP_WRITE : QSBP_LOP_NONE;

	// lane enables per data word
	wire logic [QSBP_LANES-1:0] lane_ok = wide ? '1 :
		QSBP_NARROW_MASK;
	wire logic [QSBP_LANES-1:0] en_k =
		~byte_lane_write_select_k_i & lane_ok;
	wire logic [QSBP_LANES-1:0] en_kn =
		~byte_lane_write_select_kn_i & lane_ok;

	genvar l;
	generate
		for (l = 0; l < QSBP_LANES; l++)
		begin : g_qmask
			assign q_mask[l*QSBP_LANE_W +: QSBP_LANE_W] =
				{QSBP_LANE_W{lane_ok[l]}};
		end
	endgenerate

	// array access, two words per cycle
	wire logic [QSBP_AW-1:0] wbase = wr_p2 ? wa + QSBP_PAIR_STEP : wa;
	wire logic [QSBP_AW-1:0] rbase = rd_p2 ? ra + QSBP_PAIR_STEP : ra;
	assign mem_if.we = {2{wr_p1 || wr_p2}};
	assign mem_if.lane_en = {en_kn, en_k};
	assign mem_if.waddr = {wbase + QSBP_WORD_STEP, wbase};
	assign mem_if.wdata = {d_kn_i, d_k_i};
	assign mem_if.re = rd_p1 || rd_p2;
	assign mem_if.raddr = {rbase + QSBP_WORD_STEP, rbase};

	qsbp_mem u_mem
	(
		.clk_i(clk_i),
		.ce_i(ce_i),
		.port_if(mem_if)
	);

	// transaction pipeline
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			last_op <= QSBP_LOP_NONE;
			wr_p1 <= 1'h0;
			wr_p2 <= 1'h0;
			rd_p1 <= 1'h0;
			rd_p2 <= 1'h0;
			rd_p3 <= 1'h0;
			rd_p4 <= 1'h0;
		end
		else if (ce_i)
		begin
			last_op <= next_last_op;
			wr_p1 <= start_wr;
			wr_p2 <= wr_p1;
			rd_p1 <= start_rd;
			rd_p2 <= rd_p1;
			rd_p3 <= rd_p2;
			rd_p4 <= rd_p3;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wa <= '0;
			ra <= '0;
		end
		else if (ce_i)
		begin
			if (start_wr)
				wa <= addr_i;
			if (start_rd)
				ra <= addr_i;
		end
	end

	// read data: first word on the late half, then pairs
	wire logic kn_drive = rd_p2 || rd_p3;
	wire logic k_drive = rd_p3 || rd_p4;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			q_kn_oe_o <= 1'h0;
			q_k_oe_o <= 1'h0;
			q_kn_o <= '0;
			q_k_o <= '0;
			hold <= '0;
		end
		else if (ce_i)
		begin
			q_kn_oe_o <= kn_drive;
			q_k_oe_o <= k_drive;
			q_kn_o <= kn_drive ? mem_if.rdata[0] & q_mask : '0;
			q_k_o <= k_drive ? hold : '0;
			if (kn_drive)
				hold <= mem_if.rdata[1] & q_mask;
		end
	end

	// write address log
	qsbp_fifo #(.WIDTH(QSBP_AW), .DEPTH(QSBP_LOG_DEPTH)) u_log
	(
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.in_valid_i(start_wr),
		.in_ready_o(log_ready),
		.in_data_i(addr_i),
		.out_valid_o(log_valid),
		.out_ready_i(pop_log),
		.out_data_o(log_addr)
	);

	// wishbone slave
	wire logic wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire logic wb_wr = wb_req && wb_we_i && wb_sel_i[0];
	wire logic hit_ctrl = wb_adr_i == QSBP_REG_CTRL;
	wire logic hit_status = wb_adr_i == QSBP_REG_STATUS;
	wire logic hit_log = wb_adr_i == QSBP_REG_LOG;
	wire logic wr_ctrl = wb_wr && hit_ctrl;
	wire logic clr_ovf = wb_wr && hit_status
		&& wb_dat_i[QSBP_ST_OVF];
	assign pop_log = wb_req && !wb_we_i && hit_log;
	wire logic set_ovf = start_wr && !log_ready;

	always_comb
	begin
		ctrl_word = '0;
		ctrl_word[QSBP_CTRL_WIDE] = wide;
		status_word = '0;
		status_word[QSBP_ST_RD_BUSY] = rd_p1 || rd_p2 || rd_p3 || rd_p4;
		status_word[QSBP_ST_WR_BUSY] = wr_p1 || wr_p2;
		status_word[QSBP_ST_OVF] = ovf;
		status_word[QSBP_ST_LOG_VALID] = log_valid;
		log_word = '0;
		log_word[QSBP_AW-1:0] = log_addr;
		log_word[QSBP_LOG_VALID] = log_valid;
	end

	wire logic [QSBP_WB_DW-1:0] rd_word = hit_ctrl ? ctrl_word :
		hit_status ? status_word : hit_log ? log_word : '0;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wide <= QSBP_CTRL_WIDE_RST;
			ovf <= 1'h0;
			wb_ack_o <= 1'h0;
			wb_dat_o <= '0;
		end
		else if (ce_i)
		begin
			wb_ack_o <= wb_req;
			if (wb_req)
				wb_dat_o <= rd_word;
			if (wr_ctrl)
				wide <= wb_dat_i[QSBP_CTRL_WIDE];
			if (set_ovf)
				ovf <= 1'h1;
			else if (clr_ovf)
				ovf <= 1'h0;
		end
	end

	// checks
	default clocking cb @(posedge clk_i iff ce_i);
	endclocking
	default disable iff (rst_i);

	sequence s_rd_burst;
		q_kn_oe_o ##1 (q_kn_oe_o && q_k_oe_o) ##1 q_k_oe_o;
	endsequence

	sequence s_wr_addr;
		(mem_if.waddr[0] == wa && mem_if.waddr[1] == wa + QSBP_WORD_STEP)
		##1 (mem_if.waddr[0] == wa + QSBP_PAIR_STEP
		&& mem_if.waddr[1] == wa + QSBP_PAIR_STEP + QSBP_WORD_STEP);
	endsequence

	a_rd_burst_time:
	assert property (start_rd |-> ##3 s_rd_burst)
		else $error("read burst not on time");

	a_wr_burst_addr:
	assert property (wr_p1 |-> s_wr_addr)
		else $error("write burst address order wrong");

	a_wr_addr_latch:
	assert property (start_wr |=> wr_p1 && wa == $past(addr_i))
		else $error("write address not latched");

	a_wr_two_edges:
	assert property (start_wr |=> mem_if.we == 2'h3 ##1 mem_if.we == 2'h3)
		else $error("write words not taken on two edges");

	a_sel_dont_care:
	assert property ((last_op == QSBP_LOP_READ && rd_req)
		|-> !start_rd && start_wr == wr_req)
		else $error("read select honoured twice");

	a_wr_no_repeat:
	assert property (start_wr |=> !start_wr)
		else $error("back to back write accepted");

	a_both_read_first:
	assert property ((last_op == QSBP_LOP_NONE && rd_req && wr_req)
		|-> start_rd ##1 start_wr || !wr_req)
		else $error("arbitration order wrong");

	a_narrow_lanes:
	assert property (!wide |-> mem_if.lane_en[0][3:2] == 2'h0
		&& mem_if.lane_en[1][3:2] == 2'h0)
		else $error("upper lane written in narrow mode");

	a_lanes_all_off:
	assert property ((&byte_lane_write_select_kn_i)
		|-> mem_if.lane_en[1] == 4'h0)
		else $error("write with all lane selects high");

	a_nop_high_z:
	assert property (!rd_p2 && !rd_p3 && !rd_p4
		|=> !q_k_oe_o && !q_kn_oe_o && q_kn_o == '0)
		else $error("read port driven while idle");

	a_stop_hold:
	assert property (@(posedge clk_i) disable iff (rst_i)
		!ce_i |=> $stable(q_k_o) && $stable(q_kn_oe_o) && $stable(last_op))
		else $error("state moved while clock stopped");

	a_reset_high_z:
	assert property (@(posedge clk_i) disable iff (1'b0)
		rst_i |=> !q_k_oe_o && !q_kn_oe_o)
		else $error("read port driven after reset");
endmodule // qsbp_top
`default_nettype wire

// ==== testbench/qsbp_ctrl_model.sv ====
// partner: external controller driving selects, address, data, lanes
// assumes: bench queues one command per enabled clock edge
`timescale 1ns/10ps
`default_nettype none
module qsbp_ctrl_model
(
	input wire logic clk_i,
	input wire logic ce_i,
	input wire logic full_i,
	output logic rsel_n_o,
	output logic wsel_n_o,
	output logic [qsbp_pkg::QSBP_AW-1:0] addr_o,
	output logic [qsbp_pkg::QSBP_DW-1:0] dk_o,
	output logic [qsbp_pkg::QSBP_DW-1:0] dkn_o,
	output logic [qsbp_pkg::QSBP_LANES-1:0] lk_o,
	output logic [qsbp_pkg::QSBP_LANES-1:0] lkn_o
);
	import qsbp_pkg::*;
	// {read select, write select, address}
	logic [QSBP_AW+1:0] cmd_q[$];
	logic [QSBP_AW+1:0] cmd;
	initial
	begin
		{rsel_n_o, wsel_n_o} = 2'h3;
		{addr_o, dk_o, dkn_o, lk_o, lkn_o} = '0;
	end
	always @(posedge clk_i)
	begin
		if (ce_i)
		begin
			if (cmd_q.size() > 0)
				cmd = cmd_q.pop_front();
			else
				cmd = {2'h3, QSBP_AW'($urandom())};
			rsel_n_o <= cmd[QSBP_AW+1];
			wsel_n_o <= cmd[QSBP_AW];
			addr_o <= cmd[QSBP_AW-1:0];
			dk_o <= QSBP_DW'({$urandom(), $urandom()});
			dkn_o <= QSBP_DW'({$urandom(), $urandom()});
			lk_o <= full_i ? '0 : QSBP_LANES'($urandom());
			lkn_o <= full_i ? '0 : QSBP_LANES'($urandom());
		end
	end
endmodule // qsbp_ctrl_model
`default_nettype wire

// ==== testbench/test_qsbp_top.sv ====
// bench: port logic against a word-level model, registers over wishbone
// assumes: qsbp_pkg, qsbp_mem_if and design files compiled first
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin num_errors++; \
	$display("CHECK FAILED %s exp %h got %h", nm, e, s); end end
module test_qsbp_top;
	import qsbp_pkg::*;
	logic clk_i, rst_i, ce_i, full, rsn, wsn, cyc, stb, we, ack;
	logic [QSBP_AW-1:0] addr;
	logic [QSBP_DW-1:0] dk, dkn, qk, qkn, ek, en;
	logic [QSBP_LANES-1:0] lk, lkn;
	logic qk_oe, qkn_oe, pr, pw, sr, sw, pce, wide, ovf;
	logic [3:0] adr;
	logic [31:0] wdat, rdat, r;
	logic [QSBP_DW-1:0] mem[logic [QSBP_AW-1:0]];
	logic [QSBP_DW-1:0] rw[6][4];
	logic rv[6], wv[3];
	logic [QSBP_AW-1:0] ra[6], wa[3], logq[$];
	logic [73:0] lq;
	int num_errors, compares, k;
	localparam logic [23:0] DIRS[14] = '{24'hC0_0000, 24'h80_0008,
		24'h40_0008, 24'hC0_0000, 24'h80_0010, 24'h80_0014, 24'hC0_0000,
		24'h40_0000, 24'h40_0004, 24'hC0_0000, 24'h00_000C, 24'h00_0018,
		24'h00_0004, 24'hC0_0000};
	qsbp_ctrl_model i_qsbp_ctrl_model (.clk_i(clk_i), .ce_i(ce_i),
		.full_i(full), .rsel_n_o(rsn), .wsel_n_o(wsn), .addr_o(addr),
		.dk_o(dk), .dkn_o(dkn), .lk_o(lk), .lkn_o(lkn));
	qsbp_top i_qsbp_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
		.read_port_select_n_i(rsn), .write_port_select_n_i(wsn),
		.addr_i(addr), .d_k_i(dk), .d_kn_i(dkn),
		.byte_lane_write_select_k_i(lk), .byte_lane_write_select_kn_i(lkn),
		.q_k_o(qk), .q_kn_o(qkn), .q_k_oe_o(qk_oe), .q_kn_oe_o(qkn_oe),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
	initial
	begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	task automatic give_verdict;
		if (num_errors == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic put(input logic [QSBP_AW-1:0] a,
		input logic [QSBP_DW-1:0] d, input logic [QSBP_LANES-1:0] l);
		for (int i = 0; i < QSBP_LANES; i++)
			if (!l[i] && (wide || i < 2))
				mem[a][i*QSBP_LANE_W +: QSBP_LANE_W] = d[i*QSBP_LANE_W +: QSBP_LANE_W];
	endtask
	function automatic logic [QSBP_DW-1:0] fetch(input logic [QSBP_AW-1:0] a);
		return (mem.exists(a) ? mem[a] : 'x) & (wide ? '1 : 36'h0_0003_FFFF);
	endfunction
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		{cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
		do
		begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (n >= 20)
			num_errors++;
		r = rdat;
		{cyc, stb} <= 2'b00;
	endtask
	task automatic push(input logic [1:0] c, input logic [QSBP_AW-1:0] a);
		i_qsbp_ctrl_model.cmd_q.push_back({c, a});
	endtask
	task automatic run(input logic flip);
		int n;
		n = 0;
		while (i_qsbp_ctrl_model.cmd_q.size() > 0 && n < 2000)
		begin
			@(posedge clk_i);
			ce_i <= flip ? ($urandom_range(0, 7) != 0) : 1'b1;
			n++;
		end
		@(posedge clk_i);
		ce_i <= 1'b1;
		repeat (8) @(posedge clk_i);
	endtask
	task automatic rnd(input int cnt);
		repeat (cnt) push(2'($urandom_range(0, 3)),
			QSBP_AW'($urandom_range(0, 32)) - 22'h00_0004);
		run(1'b1);
	endtask
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			{pr, pw, pce, wv[1], wv[2]} = 5'b00100;
			rv = '{default: 1'b0};
		end
		else
		begin
			if (!pce)
				`CHK("hold", lq, {qk, qkn, qk_oe, qkn_oe})
			lq = {qk, qkn, qk_oe, qkn_oe};
			pce = ce_i;
			if (ce_i)
			begin
				ek = rv[3] ? rw[3][1] : rv[4] ? rw[4][3] : '0;
				en = rv[2] ? rw[2][0] : rv[3] ? rw[3][2] : '0;
				`CHK("q_k", ek, qk)
				`CHK("q_kn", en, qkn)
				`CHK("oe", {rv[3] | rv[4], rv[2] | rv[3]}, {qk_oe, qkn_oe})
				if (wv[1])
				begin
					put(wa[1], dk, lk);
					put(wa[1] + QSBP_WORD_STEP, dkn, lkn);
				end
				if (wv[2])
				begin
					put(wa[2] + QSBP_PAIR_STEP, dk, lk);
					put(wa[2] + QSBP_PAIR_STEP + QSBP_WORD_STEP, dkn, lkn);
				end
				for (k = 5; k > 0; k--)
				begin
					{rv[k], ra[k]} = {rv[k-1], ra[k-1]};
					rw[k] = rw[k-1];
				end
				{wv[2], wa[2]} = {wv[1], wa[1]};
				for (k = 0; k < 4 && rv[1]; k++)
					rw[1][k] = fetch(ra[1] + QSBP_AW'(k));
				// upper pair read one edge later, after that edge's writes
				for (k = 2; k < 4 && rv[2]; k++)
					rw[2][k] = fetch(ra[2] + QSBP_AW'(k));
				sr = !rsn && !pr;
				sw = !wsn && !pw && !sr;
				{rv[0], ra[0], wv[1], wa[1], pr, pw} = {sr, addr, sw, addr, sr, sw};
				if (sw && logq.size() < 16)
					logq.push_back(addr);
				else if (sw)
					ovf = 1'b1;
			end
		end
	end
	initial
	begin
		#300_000;
		num_errors++;
		give_verdict();
	end
	initial
	begin
		void'($urandom(8));
		{rst_i, ce_i, full, wide, ovf, cyc, stb, we} = 8'b1111_0000;
		{adr, wdat, num_errors, compares} = '0;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, QSBP_REG_CTRL, '0);
		`CHK("ctrl", 32'h0000_0001, r)
		for (int i = -1; i < 16; i++)
		begin
			push(2'b10, QSBP_AW'(i * 4));
			push(2'b11, '0);
		end
		run(1'b0);
		full <= 1'b0;
		foreach (DIRS[i])
			push(DIRS[i][23:22], DIRS[i][21:0]);
		run(1'b0);
		wb(1'b0, QSBP_REG_STATUS, '0);
		`CHK("status", {28'h0, logq.size() > 0, ovf, 2'b00}, r)
		wb(1'b0, QSBP_REG_LOG, '0);
		wdat <= {1'b1, 9'h0, logq.pop_front()};
		@(posedge clk_i);
		`CHK("log", wdat, r)
		wb(1'b1, QSBP_REG_STATUS, 32'h0000_0004);
		ovf = 1'b0;
		wb(1'b0, QSBP_REG_STATUS, '0);
		`CHK("ovf", 1'b0, r[QSBP_ST_OVF])
		wb(1'b1, 4'hC, 32'hFFFF_FFFF);
		wb(1'b0, 4'hC, '0);
		`CHK("unmapped", 32'h0000_0000, r)
		rnd(200);
		wb(1'b1, QSBP_REG_CTRL, '0);
		wide = 1'b0;
		rnd(200);
		wb(1'b0, QSBP_REG_CTRL, '0);
		`CHK("narrow", 32'h0000_0000, r)
		give_verdict();
	end
endmodule // test_qsbp_top
`default_nettype wire
